// File: include/satp_pkg.sv
// shared constants of the strobe and timer access port
package satp_pkg;
   // host address and data widths
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   // register offsets (byte addresses within the board window)
   localparam logic [4:0] OFF_CAL_SEL_LOAD = 5'h0A;
   localparam logic [4:0] OFF_DIO_ENABLE = 5'h12;
   localparam logic [4:0] OFF_TMR_DATA = 5'h14;
   localparam logic [4:0] OFF_TMR_CMD_STAT = 5'h16;
   localparam logic [4:0] OFF_CAL_PRE_LOAD = 5'h1A;
   localparam logic [4:0] OFF_DIO_DATA = 5'h1C;
   localparam logic [4:0] OFF_EXT_STROBE = 5'h1E;
   // timer status field layout
   localparam int STAT_BP_BIT = 0;
   localparam int STAT_OUT_LSB = 1;
   localparam int STAT_OUT_MSB = 5;
   localparam int TMR_OUTS = 5;
   // command word upper byte forced to all ones
   localparam logic [7:0] TMR_CMD_HI = 8'hFF;
   // digital i/o layout
   localparam int DIO_W = 8;
   localparam int PORT_A_LSB = 0;
   localparam int PORT_A_MSB = 3;
   localparam int PORT_B_LSB = 4;
   localparam int PORT_B_MSB = 7;
   localparam int EN_A_BIT = 0;
   localparam int EN_B_BIT = 1;
   // reset values
   localparam logic [7:0] DIO_OUT_RST = 8'h00;
   localparam logic [1:0] DIO_EN_RST = 2'h0;
   localparam logic [15:0] RDATA_RST = 16'h0000;
   // timing of the external strobe pulse
   localparam int CLK_PERIOD_NS = 4;
   localparam int EXT_LOW_NS = 500;
   localparam int EXT_LOW_CYC =
      (EXT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXT_CNT_W = 7;
   // state of the external pulse generator
   typedef enum logic [0:0] {
      SATP_EXT_IDLE,
      SATP_EXT_LOW
   } satp_ext_state_t;
endpackage : satp_pkg

// File: logic/satp_top.sv
// Notes on behaviour
// RL1 - access at 1E gives one low strobe pulse
// RL2 - strobe low time at least 500 ns
// RL3 - write at 0A loads selected calibration DAC
// RL4 - write at 1A loads pregain offset DAC
// RL5 - strobe locations ignore written data value
// RL6 - data window at 14 reaches selected timer register
// RL7 - host selects timer register before window use
// RL8 - window reaches mode, load, hold, compare registers
// RL9 - command low byte passed, upper byte ones
// RL10 - status read gives counter output levels
// RL11 - status bit zero shows byte pointer
// RL12 - host uses timer in word bus mode
// RL13 - digital input read gives all eight lines
// RL14 - output register drives lines only when enabled
// RL15 - nibbles per port, each own enable bit
// RL16 - one strobe event per host bus cycle
`timescale 1ns/1ps

// three stage synchroniser: the output moves only when stages two
// and three agree, so a single metastable sample never leaks out
module satp_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] s1_ff; // first stage, read only by the second
   logic [W-1:0] s2_ff; // second stage
   logic [W-1:0] s3_ff; // third stage
   logic [W-1:0] out_ff; // agreed value

   // shift chain
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // per bit agreement filter
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_ff <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               out_ff[i] <= s3_ff[i];
            end
         end
      end
   end

   assign sync_out = out_ff;
endmodule : satp_sync

// host register logic: strobes, calibration loads, timer access port
// and the eight line digital i/o
module satp_top (
   input wire logic core_clk,
   input wire logic rst_b,
   // host register port
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // connector strobe, active low
   output logic ext_pulse_n_out,
   // calibration dac load pulses
   output logic cal_sel_load_out,
   output logic cal_pregain_load_out,
   // timer chip access, same clock as this block
   output logic tmr_wr,
   output logic tmr_rd,
   output logic tmr_cmd_sel,
   output logic [15:0] tmr_wdata,
   input wire logic [15:0] tmr_rdata,
   // timer chip pins, asynchronous
   input wire logic [4:0] tmr_out_pins,
   input wire logic byte_pointer_flag,
   // digital i/o pins
   input wire logic [3:0] port_a_lines_in,
   input wire logic [3:0] port_b_lines_in,
   output logic [3:0] port_a_lines_out,
   output logic [3:0] port_b_lines_out,
   output logic [3:0] port_a_lines_oe,
   output logic [3:0] port_b_lines_oe
);
   // address hits, one per location
   logic hit_cal_sel;
   logic hit_cal_pre;
   logic hit_ext;
   logic hit_tmr_data;
   logic hit_tmr_cs;
   logic hit_dio;
   logic hit_dio_en;
   // any host access this cycle
   logic any_acc;
   // external pulse generator state and counter
   satp_pkg::satp_ext_state_t ext_state_ff;
   satp_pkg::satp_ext_state_t nxt_ext_state;
   logic [satp_pkg::EXT_CNT_W-1:0] ext_cnt_ff;
   logic [satp_pkg::EXT_CNT_W-1:0] nxt_ext_cnt;
   logic ext_n_ff; // registered connector level
   // calibration load pulses
   logic cal_sel_ff;
   logic cal_pre_ff;
   // digital output pattern and port enables
   logic [7:0] dio_out_ff;
   logic [1:0] dio_en_ff;
   // read data register
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   // synchronised pin levels
   logic [4:0] tmr_out_sync;
   logic bp_sync;
   logic [7:0] dio_in_sync;

   // address decode; each strobe is one cycle so one event per access
   assign any_acc = reg_wr | reg_rd;
   assign hit_cal_sel = (reg_addr == satp_pkg::OFF_CAL_SEL_LOAD);
   assign hit_cal_pre = (reg_addr == satp_pkg::OFF_CAL_PRE_LOAD);
   assign hit_ext = (reg_addr == satp_pkg::OFF_EXT_STROBE);
   assign hit_tmr_data = (reg_addr == satp_pkg::OFF_TMR_DATA);
   assign hit_tmr_cs = (reg_addr == satp_pkg::OFF_TMR_CMD_STAT);
   assign hit_dio = (reg_addr == satp_pkg::OFF_DIO_DATA);
   assign hit_dio_en = (reg_addr == satp_pkg::OFF_DIO_ENABLE);

   // timer output and byte pointer pins
   satp_sync #(.W(6)) u_tmr_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .async_in({tmr_out_pins, byte_pointer_flag}),
      .sync_out({tmr_out_sync, bp_sync})
   );

   // digital i/o line levels
   // port b in the upper nibble, port a in the lower, as read back
   satp_sync #(.W(8)) u_dio_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .async_in({port_b_lines_in, port_a_lines_in}),
      .sync_out(dio_in_sync)
   );

   // external pulse next state
   always_comb begin
      nxt_ext_state = ext_state_ff;
      nxt_ext_cnt = ext_cnt_ff;
      case (ext_state_ff)
         satp_pkg::SATP_EXT_IDLE: begin
            // RL1 any access starts
            // RL16 one per cycle
            if (any_acc && hit_ext) begin
               nxt_ext_state = satp_pkg::SATP_EXT_LOW;
               nxt_ext_cnt = satp_pkg::EXT_CNT_W'(satp_pkg::EXT_LOW_CYC - 1);
            end
         end
         satp_pkg::SATP_EXT_LOW: begin
            // a new access while low restarts the count, so the pulse
            // stretches instead of showing a glitch high
            if (any_acc && hit_ext) begin
               nxt_ext_cnt = satp_pkg::EXT_CNT_W'(satp_pkg::EXT_LOW_CYC - 1);
            // RL2 hold low time
            end else if (ext_cnt_ff == '0) begin
               nxt_ext_state = satp_pkg::SATP_EXT_IDLE;
            end else begin
               nxt_ext_cnt = ext_cnt_ff - 1'b1;
            end
         end
         default: begin
            nxt_ext_state = satp_pkg::SATP_EXT_IDLE;
            nxt_ext_cnt = '0;
         end
      endcase
   end

   // external pulse registers; the pin comes straight from a flop
   // the level follows the next state, so the fall comes at the
   // taking edge and not one cycle later
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_state_ff <= satp_pkg::SATP_EXT_IDLE;
         ext_cnt_ff <= '0;
         ext_n_ff <= 1'b1;
      end else begin
         ext_state_ff <= nxt_ext_state;
         ext_cnt_ff <= nxt_ext_cnt;
         ext_n_ff <= (nxt_ext_state != satp_pkg::SATP_EXT_LOW);
      end
   end

   // calibration load pulses, one cycle after the write
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cal_sel_ff <= 1'b0;
         cal_pre_ff <= 1'b0;
      end else begin
         // RL3 selected dac load
         // RL5 data ignored
         cal_sel_ff <= reg_wr & hit_cal_sel;
         // RL4 pregain dac load
         cal_pre_ff <= reg_wr & hit_cal_pre;
      end
   end

   // digital output pattern, only the low byte is kept
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dio_out_ff <= satp_pkg::DIO_OUT_RST;
      end else if (reg_wr && hit_dio) begin
         // upper byte of the word is reserved and dropped
         dio_out_ff <= reg_wdata[7:0];
      end
   end

   // port drive enables
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dio_en_ff <= satp_pkg::DIO_EN_RST;
      end else if (reg_wr && hit_dio_en) begin
         dio_en_ff <= reg_wdata[1:0];
      end
   end

   // timer access is a pass through in the same cycle, so the chip
   // must answer a read combinationally; the host has already picked
   // the internal register with a command write beforehand
   // RL6 window pass through
   // RL8 all word registers
   // RL12 full word moves
   assign tmr_wr = reg_wr & (hit_tmr_data | hit_tmr_cs);
   assign tmr_rd = reg_rd & hit_tmr_data;
   assign tmr_cmd_sel = hit_tmr_cs;

   // command writes carry only the low byte
   always_comb begin
      tmr_wdata = reg_wdata;
      // RL9 force upper ones
      if (hit_tmr_cs) begin
         tmr_wdata = {satp_pkg::TMR_CMD_HI, reg_wdata[7:0]};
      end
   end

   // read multiplexer; unmapped and write only places read zero
   always_comb begin
      nxt_rdata = satp_pkg::RDATA_RST;
      if (reg_rd) begin
         if (hit_tmr_data) begin
            // window read: the chip answers within the strobe cycle
            nxt_rdata = tmr_rdata;
         end else if (hit_tmr_cs) begin
            // RL10 counter output levels
            nxt_rdata[satp_pkg::STAT_OUT_MSB:satp_pkg::STAT_OUT_LSB] =
               tmr_out_sync;
            // RL11 byte pointer bit
            nxt_rdata[satp_pkg::STAT_BP_BIT] = bp_sync;
         end else if (hit_dio) begin
            // RL13 all eight lines
            nxt_rdata[7:0] = dio_in_sync;
         end else if (hit_dio_en) begin
            // enables read back so software can check the drivers
            nxt_rdata[1:0] = dio_en_ff;
         end else begin
            // strobe places and holes read zero
            nxt_rdata = satp_pkg::RDATA_RST;
         end
      end
   end

   // read data stands for the one cycle after the read strobe
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= satp_pkg::RDATA_RST;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // the pattern always reaches the pins; the enable decides
   // whether the line shows it or the outside level
   // RL14 drive only enabled
   // RL15 nibble per port
   assign port_a_lines_out =
      dio_out_ff[satp_pkg::PORT_A_MSB:satp_pkg::PORT_A_LSB];
   assign port_b_lines_out =
      dio_out_ff[satp_pkg::PORT_B_MSB:satp_pkg::PORT_B_LSB];
   assign port_a_lines_oe = {4{dio_en_ff[satp_pkg::EN_A_BIT]}};
   assign port_b_lines_oe = {4{dio_en_ff[satp_pkg::EN_B_BIT]}};

   // remaining outputs
   assign reg_rdata = rdata_ff;
   assign ext_pulse_n_out = ext_n_ff;
   assign cal_sel_load_out = cal_sel_ff;
   assign cal_pregain_load_out = cal_pre_ff;
endmodule : satp_top

// File: tb/satp_tmr_model.sv
`timescale 1ns/1ps
// behavioural counter/timer chip seen through the access port
module satp_tmr_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic tmr_wr,
   input wire logic tmr_rd,
   input wire logic tmr_cmd_sel,
   input wire logic [15:0] tmr_wdata,
   output logic [15:0] tmr_rdata
);
   logic [15:0] regs_ff [18];
   // pointer to the register that the window reaches
   logic [4:0] sel_ff;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) sel_ff <= 5'h00;
      else if (tmr_wr && tmr_cmd_sel) sel_ff <= tmr_wdata[4:0];
   end
   always_ff @(posedge core_clk) begin
      if (tmr_wr && !tmr_cmd_sel) regs_ff[sel_ff] <= tmr_wdata;
   end
   // outside a read the bus is released, so show the inverse value
   assign tmr_rdata = tmr_rd ? regs_ff[sel_ff] : ~regs_ff[sel_ff];
endmodule : satp_tmr_model

// File: tb/satp_checker.sv
`timescale 1ns/1ps
// watches host port, strobes and timer access of satp_top
module satp_checker (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic ext_pulse_n_out,
   input wire logic cal_sel_load_out,
   input wire logic cal_pregain_load_out,
   input wire logic tmr_wr,
   input wire logic tmr_rd,
   input wire logic tmr_cmd_sel,
   input wire logic [15:0] tmr_wdata,
   input wire logic [15:0] tmr_rdata,
   input wire logic [3:0] port_a_lines_oe,
   input wire logic [3:0] port_b_lines_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // length of the current low phase, saturating so it never wraps
   logic [7:0] low_cnt_ff;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) low_cnt_ff <= 8'h00;
      else if (ext_pulse_n_out) low_cnt_ff <= 8'h00;
      else if (low_cnt_ff != 8'hFF) low_cnt_ff <= low_cnt_ff + 8'h01;
   end
   // a load pulse: one cycle high, then low
   sequence s_pulse(sig);
      sig ##1 !sig;
   endsequence
   property p_ext_fall;
      (reg_wr || reg_rd) && reg_addr == 5'h1E |=> !ext_pulse_n_out;
   endproperty
   a_ext_fall: assert property (p_ext_fall)
      else $error("strobe did not fall after access");
   property p_ext_min;
      $rose(ext_pulse_n_out) |-> low_cnt_ff >= 8'h7D;
   endproperty
   a_ext_min: assert property (p_ext_min)
      else $error("strobe low phase too short");
   property p_cal_sel;
      reg_wr && reg_addr == 5'h0A ##1 !(reg_wr && reg_addr == 5'h0A)
         |-> s_pulse(cal_sel_load_out);
   endproperty
   a_cal_sel: assert property (p_cal_sel)
      else $error("selected dac load pulse wrong");
   property p_cal_pre;
      reg_wr && reg_addr == 5'h1A ##1 !(reg_wr && reg_addr == 5'h1A)
         |-> s_pulse(cal_pregain_load_out);
   endproperty
   a_cal_pre: assert property (p_cal_pre)
      else $error("pregain dac load pulse wrong");
   property p_cal_src;
      cal_sel_load_out |-> $past(reg_wr) && $past(reg_addr) == 5'h0A;
   endproperty
   a_cal_src: assert property (p_cal_src)
      else $error("dac load pulse without a write");
   property p_cmd;
      reg_wr && reg_addr == 5'h16 |-> tmr_wr && tmr_cmd_sel
         && tmr_wdata == {8'hFF, reg_wdata[7:0]};
   endproperty
   a_cmd: assert property (p_cmd)
      else $error("command word not passed to timer");
   property p_win;
      reg_rd && reg_addr == 5'h14 |-> tmr_rd && !tmr_cmd_sel
         ##1 reg_rdata == $past(tmr_rdata);
   endproperty
   a_win: assert property (p_win)
      else $error("window read data not returned");
   property p_oe_src;
      $changed(port_a_lines_oe) || $changed(port_b_lines_oe)
         |-> $past(reg_wr) && $past(reg_addr) == 5'h12;
   endproperty
   a_oe_src: assert property (p_oe_src)
      else $error("drive enable moved without a write");
endmodule : satp_checker
bind satp_top satp_checker i_chk (.core_clk(core_clk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tmr_wr(tmr_wr),
   .ext_pulse_n_out(ext_pulse_n_out), .cal_sel_load_out(cal_sel_load_out),
   .cal_pregain_load_out(cal_pregain_load_out), .tmr_rd(tmr_rd),
   .tmr_cmd_sel(tmr_cmd_sel), .tmr_wdata(tmr_wdata), .tmr_rdata(tmr_rdata),
   .port_a_lines_oe(port_a_lines_oe), .port_b_lines_oe(port_b_lines_oe));

// File: tb/testbench.sv
`timescale 1ns/1ps
// self-checking bench: host accesses with expected results
module testbench;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata, tmr_wdata, tmr_rdata;
   logic ext_pulse_n_out, cal_sel_load_out, cal_pregain_load_out;
   logic tmr_wr, tmr_rd, tmr_cmd_sel;
   logic [4:0] tmr_out_pins = 5'h00;
   logic byte_pointer_flag = 1'b0;
   logic [3:0] pa_out, pb_out, pa_oe, pb_oe;
   wire logic [3:0] pa_in, pb_in;
   int mismatches = 0;
   int n_tests = 0;
   // line level: driven nibble wins, else the outside levels 5 and A
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & 4'h5);
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & 4'hA);
   always #2 core_clk = ~core_clk;
   satp_top i_dut (.core_clk(core_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tmr_wr(tmr_wr),
      .ext_pulse_n_out(ext_pulse_n_out), .cal_sel_load_out(cal_sel_load_out),
      .cal_pregain_load_out(cal_pregain_load_out), .tmr_rd(tmr_rd),
      .tmr_cmd_sel(tmr_cmd_sel), .tmr_wdata(tmr_wdata),
      .tmr_rdata(tmr_rdata), .tmr_out_pins(tmr_out_pins),
      .byte_pointer_flag(byte_pointer_flag), .port_a_lines_in(pa_in),
      .port_b_lines_in(pb_in),
      .port_a_lines_out(pa_out), .port_b_lines_out(pb_out),
      .port_a_lines_oe(pa_oe), .port_b_lines_oe(pb_oe));
   satp_tmr_model i_tmr (.core_clk(core_clk), .rst_b(rst_b),
      .tmr_wr(tmr_wr), .tmr_rd(tmr_rd), .tmr_cmd_sel(tmr_cmd_sel),
      .tmr_wdata(tmr_wdata), .tmr_rdata(tmr_rdata));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // let n edges pass, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   // one-cycle write; returns just after the taking edge
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   // one-cycle read; data stand only in the following cycle
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd
   task automatic give_verdict;
      if (mismatches == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   // watchdog: the sequence needs well under 1000 cycles
   initial begin
      #20000;
      mismatches++;
      give_verdict;
   end
   initial begin
      tick(12);
      rst_b <= 1'b1;
      rd(5'h0A, 16'h0000);
      wr(5'h0A, 16'hFFFF);
      chk({14'h0, cal_sel_load_out, cal_pregain_load_out}, 16'h0002);
      wr(5'h1A, 16'h0000);
      chk({14'h0, cal_sel_load_out, cal_pregain_load_out}, 16'h0001);
      tick(1);
      chk({14'h0, cal_sel_load_out, cal_pregain_load_out}, 16'h0000);
      // strobe by a write, then by a read
      for (int k = 0; k < 2; k++) begin
         if (k == 0) wr(5'h1E, 16'h5A5A);
         else rd(5'h1E, 16'h0000);
         chk({15'h0, ext_pulse_n_out}, 16'h0000);
         tick(124);
         chk({15'h0, ext_pulse_n_out}, 16'h0000);
         tick(1);
         chk({15'h0, ext_pulse_n_out}, 16'h0001);
      end
      // select timer registers 0, 1 and 2 before using the window
      for (int i = 0; i < 6; i++) begin
         wr(5'h16, {8'hFF, 8'(i % 3)});
         if (i < 3) wr(5'h14, 16'hC0DE + 16'(i));
         else rd(5'h14, 16'hC0DE + 16'(i - 3));
      end
      for (int j = 0; j < 2; j++) begin
         tmr_out_pins <= (j == 0) ? 5'h15 : 5'h0A;
         byte_pointer_flag <= (j == 0);
         tick(8);
         rd(5'h16, (j == 0) ? 16'h002B : 16'h0014);
      end
      // lines read back, then each port driven on its own
      rd(5'h1C, 16'h00A5);
      wr(5'h1C, 16'h003C);
      wr(5'h12, 16'h0001);
      tick(6);
      chk({8'h00, pb_oe, pa_oe}, 16'h000F);
      rd(5'h1C, 16'h00AC);
      wr(5'h12, 16'h0002);
      tick(6);
      chk({8'h00, pb_oe, pa_oe}, 16'h00F0);
      rd(5'h1C, 16'h0035);
      rd(5'h12, 16'h0002);
      give_verdict;
   end
endmodule : testbench
